/* File: common/wdm_pkg.sv */
// Purpose: Constants and types for the watchdog mode configuration block
// Assumes: 8-bit register port, one core clock
// Notes:   Offsets are byte addresses on the register port
package wdm_pkg;

  // ==========================================================
  // Register map
  localparam logic [31:0] WDM_MODE_OFS   = 32'h4000070C;
  localparam logic [31:0] WDM_STAT_OFS   = 32'h40000710;
  localparam logic [31:0] WDM_MASK_OFS   = 32'h40000714;
  localparam logic [31:0] WDM_CTRL_OFS   = 32'h40000718;

  // ==========================================================
  // Field layout and reset values
  localparam int          WDM_OVF_LSB    = 4;
  localparam int          WDM_ERM_BIT    = 2;
  localparam int          WDM_WS_LSB     = 0;
  localparam logic [7:0]  WDM_MODE_RST   = 8'h0F;
  localparam logic [7:0]  WDM_MODE_WMASK = 8'h77;
  localparam int          WDM_OVF_BASE   = 9;
  localparam int          WDM_ST_ERR_BIT = 0;
  localparam int          WDM_ST_UPD_BIT = 1;
  localparam int          WDM_CT_TRIG    = 0;

  // Error action codes
  localparam logic        WDM_ERM_NMI    = 1'b0;
  localparam logic        WDM_ERM_RESET  = 1'b1;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [2:0] ovf_sel;
    logic       erm_sel;
    logic [1:0] ws_sel;
  } wdm_cfg_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } wdm_bus_t;

endpackage : wdm_pkg

/* File: src/wdm_mode_cfg.sv */
// Purpose: Mode register of a window watchdog, with error detection
// Assumes: Trigger pulse comes from watchdog logic on the same clock
// Notes:   Settings reach the counter only at a trigger
// Functional notes
// - One software update allowed after reset, before the first trigger
// - Written value takes effect from the next trigger onward
// - After start, a write with a different value raises an error
// - After start, rewriting the held value raises no error
// - Mode register is accessed as 8-bit reads and writes
// - Bits 6-4 pick interval of 2^(9+code) count clock periods
// - Bit 2 picks error action: 0 interrupt request, 1 reset
// - Bits 1-0 pick open window 25, 50, 75 or 100 percent
`timescale 1ns/1ns
module wdm_mode_cfg #(
  parameter int OVF_W = 17
) (
  // Clock and reset
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_b_in,
  // Register port
  input  wire logic [31:0]               addr_in,
  input  wire logic [7:0]                wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [7:0]                rdata_out,
  // Watchdog side
  input  wire logic                      trigger_in,
  output wdm_pkg::wdm_cfg_t              cfg_out,
  output logic      [OVF_W-1:0]          interval_out,
  output logic      [1:0]                window_q_out,
  output logic                           started_out,
  output logic                           err_pulse_out,
  output logic                           nmi_req_out,
  output logic                           reset_req_out,
  // Interrupt
  output logic                           irq_out
);

  // ==========================================================
  // Reset values, reserved bits already cleared
  localparam logic [7:0] MODE_RST =
    wdm_pkg::WDM_MODE_RST & wdm_pkg::WDM_MODE_WMASK;
  localparam wdm_pkg::wdm_cfg_t ACT_RST = {MODE_RST[6:4], MODE_RST[2],
                                           MODE_RST[1:0]};

  // ==========================================================
  // Helpers
  function automatic logic [OVF_W-1:0] ovf_count(input logic [2:0] sel);
    ovf_count = OVF_W'(1) << (wdm_pkg::WDM_OVF_BASE + int'(sel));
  endfunction : ovf_count

  function automatic logic [7:0] cfg_byte(input wdm_pkg::wdm_cfg_t c);
    cfg_byte = {1'b0, c.ovf_sel, 1'b0, c.erm_sel, c.ws_sel};
  endfunction : cfg_byte

  function automatic logic reg_hit(input logic [31:0] a,
                                   input logic [31:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  // ==========================================================
  // State
  logic [7:0]        mode_q, mode_d;
  wdm_pkg::wdm_cfg_t act_q, act_d;
  logic              start_q, start_d;
  logic              upd_q, upd_d;
  logic [1:0]        stat_q, stat_d;
  logic [1:0]        mask_q, mask_d;
  logic [7:0]        rdata_q, rdata_d;
  logic              err_q, err_d;
  logic              wr_mode, wr_stat, wr_mask, wr_ctrl, trig;
  logic              bad_wr, first_wr;
  logic [7:0]        wval;

  assign wr_mode  = wr_in && reg_hit(addr_in, wdm_pkg::WDM_MODE_OFS);
  assign wr_stat  = wr_in && reg_hit(addr_in, wdm_pkg::WDM_STAT_OFS);
  assign wr_mask  = wr_in && reg_hit(addr_in, wdm_pkg::WDM_MASK_OFS);
  assign wr_ctrl  = wr_in && reg_hit(addr_in, wdm_pkg::WDM_CTRL_OFS);
  assign trig     = trigger_in ||
                    (wr_ctrl && wdata_in[wdm_pkg::WDM_CT_TRIG]);
  assign wval     = wdata_in & wdm_pkg::WDM_MODE_WMASK;
  assign first_wr = wr_mode && !start_q && !upd_q;
  assign bad_wr   = wr_mode && !first_wr && (wval != mode_q);

  // ==========================================================
  // Mode register, one update before the first trigger
  always_comb begin
    mode_d = mode_q;
    upd_d  = upd_q;
    if (first_wr) begin
      mode_d = wval;
      upd_d  = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_q <= MODE_RST;
      upd_q  <= 1'b0;
    end else begin
      mode_q <= mode_d;
      upd_q  <= upd_d;
    end
  end

  // ==========================================================
  // Active settings, applied only at a trigger
  always_comb begin
    act_d   = act_q;
    start_d = start_q;
    err_d   = bad_wr;
    if (trig) begin
      start_d       = 1'b1;
      act_d.ovf_sel = mode_d[wdm_pkg::WDM_OVF_LSB +: 3];
      act_d.erm_sel = mode_d[wdm_pkg::WDM_ERM_BIT];
      act_d.ws_sel  = mode_d[wdm_pkg::WDM_WS_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      act_q   <= ACT_RST;
      start_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      act_q   <= act_d;
      start_q <= start_d;
      err_q   <= err_d;
    end
  end

  // ==========================================================
  // Status and mask
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = wdata_in[1:0];
    end
    if (wr_stat) begin
      stat_d = stat_q & ~wdata_in[1:0];
    end
    // Set wins over a clear in the same cycle
    if (bad_wr) begin
      stat_d[wdm_pkg::WDM_ST_ERR_BIT] = 1'b1;
    end
    if (first_wr) begin
      stat_d[wdm_pkg::WDM_ST_UPD_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stat_q <= 2'h0;
      mask_q <= 2'h0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    rdata_d = 8'h00;
    if (rd_in) begin
      case (addr_in)
        wdm_pkg::WDM_MODE_OFS: rdata_d = mode_q;
        wdm_pkg::WDM_STAT_OFS: rdata_d = {6'h00, stat_q};
        wdm_pkg::WDM_MASK_OFS: rdata_d = {6'h00, mask_q};
        wdm_pkg::WDM_CTRL_OFS: rdata_d = {6'h00, upd_q, start_q};
        default:               rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_out     = rdata_q;
  assign cfg_out       = act_q;
  assign interval_out  = ovf_count(act_q.ovf_sel);
  assign window_q_out  = act_q.ws_sel;
  assign started_out   = start_q;
  assign err_pulse_out = err_q;
  assign nmi_req_out   = err_q && (act_q.erm_sel == wdm_pkg::WDM_ERM_NMI);
  assign reset_req_out = err_q && (act_q.erm_sel == wdm_pkg::WDM_ERM_RESET);
  assign irq_out       = |(stat_q & mask_q);

  // ==========================================================
  // Checks
  a_change_errs: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (wr_in && addr_in == wdm_pkg::WDM_MODE_OFS && start_q && upd_q
     && ((wdata_in & 8'h77) != mode_q)) |=> err_pulse_out)
    else $error("changed mode write gave no error");
  a_same_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (wr_in && addr_in == wdm_pkg::WDM_MODE_OFS
     && ((wdata_in & 8'h77) == mode_q)) |=> !err_pulse_out)
    else $error("same value write gave an error");
  a_once_only: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    upd_q |=> $stable(mode_q))
    else $error("mode changed after first update");
  a_first_takes: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (wr_in && addr_in == wdm_pkg::WDM_MODE_OFS && !upd_q && !start_q)
    |=> mode_q == $past(wdata_in & 8'h77))
    else $error("first update not stored");
  a_hold_till_trig: assert property (@(posedge core_clk_in)
    disable iff (!rst_b_in) !trig |=> $stable(cfg_out))
    else $error("settings moved without trigger");
  a_trig_applies: assert property (@(posedge core_clk_in)
    disable iff (!rst_b_in) trig ##1 !trig |-> window_q_out == mode_q[1:0])
    else $error("window not applied at trigger");
  a_interval_val: assert property (@(posedge core_clk_in)
    disable iff (!rst_b_in)
    interval_out == (17'h00200 << cfg_out.ovf_sel))
    else $error("interval count wrong");
  a_action_sel: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    err_pulse_out |-> (reset_req_out == cfg_out.erm_sel)
    && (nmi_req_out == !cfg_out.erm_sel))
    else $error("error action routed wrong");
  a_resv_zero: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    $past(rd_in && addr_in == wdm_pkg::WDM_MODE_OFS)
    |-> (rdata_out[7] == 1'b0 && rdata_out[3] == 1'b0))
    else $error("reserved bits read nonzero");

  a_err_sets_stat: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    bad_wr |=> stat_q[wdm_pkg::WDM_ST_ERR_BIT])
    else $error("error write left status clear");

  a_early_quiet: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    first_wr |=> !err_pulse_out)
    else $error("first update gave an error");

  a_start_sticky: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    start_q |=> started_out)
    else $error("started flag dropped");

  a_trig_starts: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    trig |=> started_out)
    else $error("trigger did not start");

  a_cfg_from_mode: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    trig |=> (cfg_byte(cfg_out) == mode_q))
    else $error("settings differ from mode after trigger");

  a_resv_stored: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (mode_q[7] == 1'b0) && (mode_q[3] == 1'b0))
    else $error("reserved bit stored");

  a_action_onehot: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    !(nmi_req_out && reset_req_out))
    else $error("both error actions raised");

  a_req_from_err: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (nmi_req_out || reset_req_out) |-> err_pulse_out)
    else $error("error action without error");

  a_rdata_idle: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    !$past(rd_in) |-> (rdata_out == 8'h00))
    else $error("read data outside its cycle");

  a_window_hold: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    !trig |=> $stable(window_q_out))
    else $error("window moved without trigger");

  a_upd_sticky: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    upd_q |=> upd_q)
    else $error("update flag dropped");

  a_no_late_store: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (wr_mode && start_q) |=> $stable(mode_q))
    else $error("mode stored after start");

  a_second_errs: assert property (
    @(posedge core_clk_in) disable iff (!rst_b_in)
    (wr_mode && upd_q && (wval != mode_q)) |=> err_pulse_out)
    else $error("second differing update gave no error");

  c_first_upd: cover property (@(posedge core_clk_in) first_wr);
  c_trig:      cover property (@(posedge core_clk_in) trigger_in ##1 started_out);
  c_err_nmi:   cover property (@(posedge core_clk_in) nmi_req_out);
  c_err_rst:   cover property (@(posedge core_clk_in) reset_req_out);
  c_sw_trig:   cover property (@(posedge core_clk_in) wr_ctrl && wdata_in[0]);

endmodule : wdm_mode_cfg

/* File: tb/test_wdm_mode_cfg.sv */
// Purpose: Self-checking bench for the watchdog mode register
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Reset, update, trigger and error once per interval code
`timescale 1ns/1ns
module test_wdm_mode_cfg;
  // ============================================================
  // Signals
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [31:0]       addr = 32'h0;
  logic [7:0]        wdata = 8'h00;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              trig = 1'b0;
  logic              rd_d = 1'b0;
  logic [7:0]        rdata;
  logic [7:0]        m;
  wdm_pkg::wdm_cfg_t cfg;
  logic [16:0]       intv;
  logic [1:0]        win;
  logic              started;
  logic              err;
  logic              nmi;
  logic              rst_req;
  logic              irq;
  logic [7:0]        exp_q[$];
  int                fail_count = 0;
  int                samples_checked = 0;
  int                seed = 72658;

  initial begin
    forever #20 clk = ~clk;
  end

  wdm_mode_cfg u_dut (
    .core_clk_in(clk), .rst_b_in(rst_b), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .trigger_in(trig), .cfg_out(cfg), .interval_out(intv),
    .window_q_out(win), .started_out(started), .err_pulse_out(err),
    .nmi_req_out(nmi), .reset_req_out(rst_req), .irq_out(irq));

  // ============================================================
  // Tasks
  task chk(input string n, input logic [16:0] s, input logic [16:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task conclude;
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task wr_reg(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task rd_reg(input logic [31:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  task settle;
    @(posedge clk);
    #1;
  endtask : settle

  // ============================================================
  // Read data watcher
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d && exp_q.size() > 0) begin
      chk("rdata", 17'(rdata), 17'(exp_q.pop_front()));
    end
  end

  // ============================================================
  // Main sequence
  initial begin
    for (int k = 0; k < 8; k++) begin
      rst_b <= 1'b0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      m = (8'($random(seed)) & 8'h8C) | {1'b0, 3'(k), 2'b00, 2'(k)};
      rd_reg(wdm_pkg::WDM_MODE_OFS, 8'h07);
      chk("interval", intv, 17'd512);
      wr_reg(wdm_pkg::WDM_MODE_OFS, m);
      rd_reg(wdm_pkg::WDM_MODE_OFS, m & 8'h77);
      chk("cfg", 17'(cfg), 17'h07);
      if (k[0]) begin
        wr_reg(wdm_pkg::WDM_CTRL_OFS, 8'h01);
      end else begin
        @(posedge clk);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        #1;
      end
      chk("cfg", 17'(cfg), 17'({m[6:4], m[2], m[1:0]}));
      chk("interval", intv, 17'(1) << (9 + k));
      chk("window", 17'(win), 17'(k[1:0]));
      chk("started", 17'(started), 17'h1);
      rd_reg(wdm_pkg::WDM_CTRL_OFS, 8'h03);
      wr_reg(wdm_pkg::WDM_MODE_OFS, m);
      chk("err", 17'(err), 17'h0);
      wr_reg(wdm_pkg::WDM_MODE_OFS, m ^ 8'h01);
      chk("err", 17'(err), 17'h1);
      chk("reset", 17'(rst_req), 17'(m[2]));
      chk("nmi", 17'(nmi), 17'(!m[2]));
      settle;
      chk("irq", 17'(irq), 17'h0);
      wr_reg(wdm_pkg::WDM_MASK_OFS, 8'h01);
      settle;
      chk("irq", 17'(irq), 17'h1);
      wr_reg(wdm_pkg::WDM_STAT_OFS, 8'h01);
      settle;
      chk("irq", 17'(irq), 17'h0);
      rd_reg(wdm_pkg::WDM_STAT_OFS, 8'h02);
      rd_reg(wdm_pkg::WDM_MODE_OFS, m & 8'h77);
      rd_reg(32'h40000720, 8'h00);
    end
    settle;
    settle;
    conclude;
  end

  initial begin
    #100000;
    fail_count++;
    conclude;
  end
endmodule : test_wdm_mode_cfg
